//--- rtl/global_config_register_bank.sv
// chip-level global configuration registers behind an index/data port pair
// assumes config_mode comes from the entry/exit sequence logic outside,
// and every reset input is synchronous to sys_clk and active high
`default_nettype none

module global_config_register_bank
	import global_config_pkg::*;
#(
	parameter logic [7:0] DEVICE_IDENTITY = 8'hA5, // arbitrary value
	parameter logic [7:0] DEVICE_REVISION = 8'h01 // arbitrary value
)
(
	input wire logic sys_clk, // 25 MHz clock
	input wire logic reset, // hard reset
	input wire logic main_power_on_reset, // main supply power-on
	input wire logic standby_supply_power_on_reset, // standby power-on
	input wire logic config_addr_strap, // default port select
	input wire logic config_mode, // device in configuration mode
	input wire io_req_t io_req, // host i/o cycle
	output logic [7:0] io_rdata, // read data
	output logic io_rdata_valid, // read data strobe
	output logic [7:0] current_unit, // chosen logical unit
	output logic soft_reset_pulse, // soft reset to unit banks
	output logic [7:0] unit_power, // per-unit power enables
	output logic [7:0] unit_auto_power, // auto power enables
	output logic pll_off, // pll stopped
	output logic oscillator_stop, // oscillator stopped
	output logic baud_clock_generator_enable, // baud clock running
	output logic qualify_16bit_address, // 16-bit qualification
	output logic [15:0] config_port_base // active port base
);

	// ==========================================================
	// declarations
	logic hard_clear;
	logic address_clear;
	logic index_hit;
	logic data_hit;
	logic index_write;
	logic data_write;
	logic data_read;
	logic index_read;
	logic soft_req;
	logic [7:0] cfg_index;
	logic [7:0] unit_select;
	logic [7:0] power_stored;
	logic serial2_power;
	logic [7:0] unit_power_control;
	logic [7:0] auto_power_management;
	logic [7:0] oscillator_control;
	logic [7:0] config_port_address_low;
	logic [7:0] config_port_address_high;
	logic [7:0] address_low_default;
	logic [7:0] read_value;
	global_regs_t regs;

	// ==========================================================
	// helpers
	function automatic logic in_global(input logic [7:0] idx);
		return idx <= IDX_LAST_GLOBAL;
	endfunction

	function automatic logic write_to(
		input logic strobe,
		input logic [7:0] idx,
		input logic [7:0] want
	);
		return strobe && (idx == want);
	endfunction

	// ==========================================================
	// elaboration checks
	if (ADDRESS_LOW_MASK[0] || ADDRESS_LOW_RESET_STRAP0[0]
		|| ADDRESS_LOW_RESET_STRAP1[0])
	begin : g_odd_port
		$error("global_config_register_bank: port base must be even");
	end

	// ==========================================================
	// reset grouping
	always_comb
	begin
		hard_clear = reset || main_power_on_reset
			|| standby_supply_power_on_reset;
		// port address survives a standby power-on reset
		address_clear = reset || main_power_on_reset;
		address_low_default = config_addr_strap
			? ADDRESS_LOW_RESET_STRAP1
			: ADDRESS_LOW_RESET_STRAP0;
	end

	// ==========================================================
	// port decode
	config_port_decoder #(
		.ADDR_BITS(QUAL_WIDE_BITS)
	) u_port_decoder (
		.io_addr(io_req.addr),
		.port_base(config_port_base),
		.qualify_wide(qualify_16bit_address),
		.index_hit(index_hit),
		.data_hit(data_hit)
	);

	always_comb
	begin
		index_write = config_mode && io_req.write && index_hit;
		index_read = config_mode && io_req.read && index_hit;
		// data writes past the global range are dropped
		data_write = config_mode && io_req.write && data_hit
			&& in_global(cfg_index);
		data_read = config_mode && io_req.read && data_hit;
		soft_req = write_to(data_write, cfg_index, IDX_CONFIG_CONTROL)
			&& io_req.wdata[SOFT_RESET_BIT];
	end

	// ==========================================================
	// index register
	always_ff @(posedge sys_clk)
	begin
		if (hard_clear)
		begin
			cfg_index <= INDEX_RESET;
		end
		else if (index_write)
		begin
			cfg_index <= io_req.wdata;
		end
	end

	// ==========================================================
	// soft reset strobe, never stored so it reads zero
	always_ff @(posedge sys_clk)
	begin
		if (hard_clear)
		begin
			soft_reset_pulse <= 1'b0;
		end
		else
		begin
			soft_reset_pulse <= soft_req;
		end
	end

	// ==========================================================
	// logical unit selection
	always_ff @(posedge sys_clk)
	begin
		if (hard_clear || soft_req)
		begin
			unit_select <= UNIT_SELECT_RESET;
		end
		else if (write_to(data_write, cfg_index, IDX_UNIT_SELECT))
		begin
			unit_select <= io_req.wdata;
		end
	end

	// ==========================================================
	// unit power control
	always_ff @(posedge sys_clk)
	begin
		if (hard_clear || soft_req)
		begin
			power_stored <= UNIT_POWER_RESET;
		end
		else if (write_to(data_write, cfg_index, IDX_UNIT_POWER_CONTROL))
		begin
			power_stored <= io_req.wdata & POWER_CONTROL_MASK;
		end
	end

	// serial 2 power survives hard, main and soft resets
	always_ff @(posedge sys_clk)
	begin
		if (standby_supply_power_on_reset)
		begin
			serial2_power <= UNIT_POWER_RESET[SERIAL2_POWER_BIT];
		end
		else if (write_to(data_write, cfg_index, IDX_UNIT_POWER_CONTROL))
		begin
			serial2_power <= io_req.wdata[SERIAL2_POWER_BIT];
		end
	end

	always_comb
	begin
		unit_power_control = power_stored;
		unit_power_control[SERIAL2_POWER_BIT] = serial2_power;
	end

	// ==========================================================
	// intelligent power management, kept by soft reset
	always_ff @(posedge sys_clk)
	begin
		if (hard_clear)
		begin
			auto_power_management <= AUTO_POWER_RESET;
		end
		else if (write_to(data_write, cfg_index,
			IDX_AUTO_POWER_MANAGEMENT))
		begin
			auto_power_management <= io_req.wdata & AUTO_POWER_MASK;
		end
	end

	// ==========================================================
	// oscillator control, kept by soft reset
	always_ff @(posedge sys_clk)
	begin
		if (hard_clear)
		begin
			oscillator_control <= OSCILLATOR_RESET;
		end
		else if (write_to(data_write, cfg_index, IDX_OSCILLATOR_CONTROL))
		begin
			oscillator_control <= io_req.wdata & OSCILLATOR_MASK;
		end
	end

	always_comb
	begin
		pll_off = oscillator_control[PLL_OFF_BIT];
		oscillator_stop = oscillator_control[CLOCK_STATE_LSB+:2]
			== CLOCK_STATE_STOP;
		baud_clock_generator_enable = !oscillator_stop;
		qualify_16bit_address = oscillator_control[QUALIFY_16_BIT];
	end

	// ==========================================================
	// configuration port address, pending bytes
	always_ff @(posedge sys_clk)
	begin
		if (address_clear)
		begin
			config_port_address_low <= address_low_default;
		end
		else if (write_to(data_write, cfg_index,
			IDX_CONFIG_PORT_ADDRESS_LOW))
		begin
			config_port_address_low <= io_req.wdata & ADDRESS_LOW_MASK;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (address_clear)
		begin
			config_port_address_high <= ADDRESS_HIGH_RESET;
		end
		else if (write_to(data_write, cfg_index,
			IDX_CONFIG_PORT_ADDRESS_HIGH))
		begin
			config_port_address_high <= io_req.wdata;
		end
	end

	// active base only moves on the high byte write
	always_ff @(posedge sys_clk)
	begin
		if (address_clear)
		begin
			config_port_base <= {ADDRESS_HIGH_RESET, address_low_default};
		end
		else if (write_to(data_write, cfg_index,
			IDX_CONFIG_PORT_ADDRESS_HIGH))
		begin
			config_port_base <= {io_req.wdata,
				config_port_address_low};
		end
	end

	// ==========================================================
	// read path
	always_comb
	begin
		regs.unit_select = unit_select;
		regs.unit_power_control = unit_power_control;
		regs.auto_power_management = auto_power_management;
		regs.oscillator_control = oscillator_control;
		regs.config_port_address_low = config_port_address_low;
		regs.config_port_address_high = config_port_address_high;
	end

	global_read_mux u_read_mux (
		.index(cfg_index),
		.regs(regs),
		.identity(DEVICE_IDENTITY),
		.revision(DEVICE_REVISION),
		.read_value(read_value)
	);

	always_ff @(posedge sys_clk)
	begin
		if (hard_clear)
		begin
			io_rdata <= 8'h00;
			io_rdata_valid <= 1'b0;
		end
		else
		begin
			io_rdata_valid <= data_read || index_read;
			// index port reads back the held index
			if (index_read)
			begin
				io_rdata <= cfg_index;
			end
			else if (data_read)
			begin
				io_rdata <= read_value;
			end
		end
	end

	// ==========================================================
	// outputs toward unit banks and peripherals
	always_comb
	begin
		current_unit = unit_select;
		unit_power = unit_power_control;
		unit_auto_power = auto_power_management;
	end

endmodule

`default_nettype wire

//--- rtl/global_config_pkg.sv
// global configuration register bank: indices, fields, reset values, types
// assumes one 25 MHz clock and synchronous reset inputs
`default_nettype none

package global_config_pkg;

	// ==========================================================
	// register indices
	localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
	localparam logic [7:0] IDX_UNIT_SELECT = 8'h07;
	localparam logic [7:0] IDX_DEVICE_IDENTITY = 8'h20;
	localparam logic [7:0] IDX_DEVICE_REVISION = 8'h21;
	localparam logic [7:0] IDX_UNIT_POWER_CONTROL = 8'h22;
	localparam logic [7:0] IDX_AUTO_POWER_MANAGEMENT = 8'h23;
	localparam logic [7:0] IDX_OSCILLATOR_CONTROL = 8'h24;
	localparam logic [7:0] IDX_CONFIG_PORT_ADDRESS_LOW = 8'h26;
	localparam logic [7:0] IDX_CONFIG_PORT_ADDRESS_HIGH = 8'h27;
	localparam logic [7:0] IDX_LAST_GLOBAL = 8'h2F;

	// ==========================================================
	// field positions
	localparam int SOFT_RESET_BIT = 0;
	localparam int SERIAL2_POWER_BIT = 5;
	localparam int PLL_OFF_BIT = 1;
	localparam int CLOCK_STATE_LSB = 2;
	localparam int QUALIFY_16_BIT = 6;
	localparam logic [1:0] CLOCK_STATE_STOP = 2'h3;

	// ==========================================================
	// implemented-bit masks and reset values
	localparam logic [7:0] POWER_CONTROL_MASK = 8'h5D;
	localparam logic [7:0] AUTO_POWER_MASK = 8'h79;
	localparam logic [7:0] OSCILLATOR_MASK = 8'h4E;
	localparam logic [7:0] ADDRESS_LOW_MASK = 8'hFE;
	localparam logic [7:0] UNIT_SELECT_RESET = 8'h00;
	localparam logic [7:0] UNIT_POWER_RESET = 8'h00;
	localparam logic [7:0] AUTO_POWER_RESET = 8'h00;
	localparam logic [7:0] OSCILLATOR_RESET = 8'h44;
	localparam logic [7:0] ADDRESS_LOW_RESET_STRAP0 = 8'h2E;
	localparam logic [7:0] ADDRESS_LOW_RESET_STRAP1 = 8'h4E;
	localparam logic [7:0] ADDRESS_HIGH_RESET = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;

	// ==========================================================
	// address qualification widths
	localparam int QUAL_NARROW_BITS = 12;
	localparam int QUAL_WIDE_BITS = 16;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic write;
		logic read;
		logic [15:0] addr;
		logic [7:0] wdata;
	} io_req_t;

	typedef struct packed {
		logic [7:0] unit_select;
		logic [7:0] unit_power_control;
		logic [7:0] auto_power_management;
		logic [7:0] oscillator_control;
		logic [7:0] config_port_address_low;
		logic [7:0] config_port_address_high;
	} global_regs_t;

endpackage

`default_nettype wire

//--- rtl/config_port_decoder.sv
// decodes the index and data ports from the host i/o address
// assumes the base address is even; data port sits at base + 1
`default_nettype none

module config_port_decoder
	import global_config_pkg::*;
#(
	parameter int ADDR_BITS = QUAL_WIDE_BITS
)
(
	input wire logic [ADDR_BITS-1:0] io_addr, // host i/o address
	input wire logic [ADDR_BITS-1:0] port_base, // active even base
	input wire logic qualify_wide, // compare all address bits
	output logic index_hit, // address is the index port
	output logic data_hit // address is the data port
);

	logic [ADDR_BITS-1:0] qual_mask;
	logic [ADDR_BITS-1:0] data_port;

	if (ADDR_BITS <= QUAL_NARROW_BITS)
	begin : g_bad_width
		$error("config_port_decoder: ADDR_BITS too small");
	end

	// upper bits only compared in wide mode
	always_comb
	begin
		qual_mask = {{(ADDR_BITS - QUAL_NARROW_BITS){qualify_wide}},
			{QUAL_NARROW_BITS{1'b1}}};
		data_port = {port_base[ADDR_BITS-1:1], 1'b1};
		index_hit = ((io_addr ^ port_base) & qual_mask) == '0;
		data_hit = ((io_addr ^ data_port) & qual_mask) == '0;
	end

endmodule

`default_nettype wire

//--- rtl/global_read_mux.sv
// read-back selection for the global register range
// assumes stored registers already hold zero in unimplemented bits
`default_nettype none

module global_read_mux
	import global_config_pkg::*;
(
	input wire logic [7:0] index, // selected register index
	input wire global_regs_t regs, // stored register values
	input wire logic [7:0] identity, // hard-wired identity code
	input wire logic [7:0] revision, // hard-wired revision
	output logic [7:0] read_value // value for the data port
);

	// full eight-bit compare, unlisted indices read zero
	always_comb
	begin
		unique case (index)
			IDX_UNIT_SELECT: read_value = regs.unit_select;
			IDX_DEVICE_IDENTITY: read_value = identity;
			IDX_DEVICE_REVISION: read_value = revision;
			IDX_UNIT_POWER_CONTROL: read_value = regs.unit_power_control;
			IDX_AUTO_POWER_MANAGEMENT:
				read_value = regs.auto_power_management;
			IDX_OSCILLATOR_CONTROL: read_value = regs.oscillator_control;
			IDX_CONFIG_PORT_ADDRESS_LOW:
				read_value = regs.config_port_address_low;
			IDX_CONFIG_PORT_ADDRESS_HIGH:
				read_value = regs.config_port_address_high;
			default: read_value = 8'h00;
		endcase
	end

endmodule

`default_nettype wire

//--- testbench/global_config_bank_assertions.sv
// port checker for the global configuration register bank
// assumes binding onto the bank; all resets synchronous, active high
`default_nettype none

module global_config_checker
	import global_config_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic reset, // hard reset
	input wire logic main_power_on_reset, // main por
	input wire logic standby_supply_power_on_reset, // standby por
	input wire logic config_mode, // config mode
	input wire io_req_t io_req, // host cycle
	input wire logic [7:0] io_rdata, // read data
	input wire logic io_rdata_valid, // read strobe
	input wire logic [7:0] current_unit, // unit
	input wire logic soft_reset_pulse, // soft reset
	input wire logic [7:0] unit_power, // power
	input wire logic [7:0] unit_auto_power, // auto power
	input wire logic pll_off, // pll off
	input wire logic oscillator_stop, // osc off
	input wire logic baud_clock_generator_enable, // baud on
	input wire logic qualify_16bit_address, // wide match
	input wire logic [15:0] config_port_base // base
);
	timeunit 1ns;
	timeprecision 1ns;
	logic any_reset;
	assign any_reset = reset | main_power_on_reset
		| standby_supply_power_on_reset;
	// ==========================================================
	// properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (any_reset);
	valid_needs_read_a:
		assert property (io_rdata_valid |-> $past(io_req.read & config_mode))
		else $error("read strobe without taken read");
	mode_gate_a:
		assert property (!config_mode |=> !io_rdata_valid
			&& $stable(current_unit) && $stable(config_port_base))
		else $error("access outside configuration mode");
	rdata_hold_a:
		assert property (!io_rdata_valid && !$past(any_reset)
			|-> $stable(io_rdata))
		else $error("read data moved without strobe");
	soft_pulse_a:
		assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset pulse too long");
	soft_clear_a:
		assert property (soft_reset_pulse |-> current_unit == 8'h00
			&& (unit_power & 8'hDF) == 8'h00)
		else $error("soft reset left registers set");
	reserved_bits_a:
		assert property (((unit_power & 8'h82) == 8'h00)
			&& ((unit_auto_power & 8'h86) == 8'h00))
		else $error("reserved power bit set");
	baud_inverse_a:
		assert property (baud_clock_generator_enable == !oscillator_stop)
		else $error("baud enable not inverse of stop");
	base_move_a:
		assert property ($changed(config_port_base) && !$past(any_reset)
			|-> $past(io_req.write & config_mode) && !config_port_base[0])
		else $error("port base moved without write");
	osc_reset_a:
		assert property (disable iff (1'b0) (reset | main_power_on_reset)
			|=> !pll_off && !oscillator_stop && qualify_16bit_address)
		else $error("oscillator reset value wrong");
	regs_hold_a:
		assert property (!$past(io_req.write & config_mode)
			&& !$past(any_reset) |-> $stable(current_unit)
			&& $stable(unit_power) && $stable(unit_auto_power)
			&& $stable({pll_off, oscillator_stop,
			qualify_16bit_address}) && $stable(config_port_base))
		else $error("register moved without write");
	cover property (io_rdata_valid);
	cover property (soft_reset_pulse);
	cover property ($changed(config_port_base));
endmodule

bind global_config_register_bank global_config_checker chk (
	.sys_clk(sys_clk), .reset(reset),
	.main_power_on_reset(main_power_on_reset),
	.standby_supply_power_on_reset(standby_supply_power_on_reset),
	.config_mode(config_mode), .io_req(io_req), .io_rdata(io_rdata),
	.io_rdata_valid(io_rdata_valid), .current_unit(current_unit),
	.soft_reset_pulse(soft_reset_pulse), .unit_power(unit_power),
	.unit_auto_power(unit_auto_power), .pll_off(pll_off),
	.oscillator_stop(oscillator_stop),
	.baud_clock_generator_enable(baud_clock_generator_enable),
	.qualify_16bit_address(qualify_16bit_address),
	.config_port_base(config_port_base)
);

`default_nettype wire

//--- testbench/config_host_model.sv
// host bus controller issuing index/data port cycles
// assumes one-cycle strobes, driven at the falling edge
`default_nettype none

module config_host_model
	import global_config_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic [7:0] io_rdata, // read data
	input wire logic io_rdata_valid, // read strobe
	output var io_req_t io_req // host cycle
);
	timeunit 1ns;
	timeprecision 1ns;
	initial io_req = '0;
	// ==========================================================
	// bus cycles; idle bus shows inverted last value
	task automatic io_cycle(input logic wr, input logic [15:0] addr,
		input logic [7:0] d, output logic [7:0] q, output logic got);
		@(negedge sys_clk);
		io_req = '{write: wr, read: !wr, addr: addr, wdata: d};
		@(negedge sys_clk);
		got = io_rdata_valid;
		q = io_rdata;
		io_req = '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: ~d};
	endtask
	task automatic cfg_write(input logic [15:0] base,
		input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		logic got;
		io_cycle(1'b1, base, idx, q, got);
		io_cycle(1'b1, base | 16'h0001, d, q, got);
	endtask
	task automatic cfg_read(input logic [15:0] base, input logic [7:0] idx,
		output logic [7:0] q, output logic got);
		io_cycle(1'b1, base, idx, q, got);
		io_cycle(1'b0, base | 16'h0001, ~idx, q, got);
	endtask
endmodule

`default_nettype wire

//--- testbench/test_global_config_register_bank.sv
// self-checking bench for the global configuration register bank
// assumes the host model drives every register access
`default_nettype none

module test_global_config_register_bank
	import global_config_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ID_CODE = 8'h3C; // arbitrary value
	localparam logic [7:0] REV_CODE = 8'h07; // arbitrary value
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic main_por = 1'b1;
	logic standby_por = 1'b1;
	logic strap = 1'b0;
	logic config_mode = 1'b1;
	io_req_t io_req;
	logic [7:0] io_rdata, current_unit, unit_power, unit_auto_power, rd;
	logic io_rdata_valid, soft_reset_pulse, pll_off, osc_stop, baud_on;
	logic qualify, got;
	logic [15:0] port_base;
	logic [15:0] base = 16'h002E;
	int mismatches = 0;
	int cmp_count = 0;

	global_config_register_bank #(.DEVICE_IDENTITY(ID_CODE),
		.DEVICE_REVISION(REV_CODE)) uut (
		.sys_clk(sys_clk), .reset(reset), .main_power_on_reset(main_por),
		.standby_supply_power_on_reset(standby_por),
		.config_addr_strap(strap), .config_mode(config_mode),
		.io_req(io_req), .io_rdata(io_rdata),
		.io_rdata_valid(io_rdata_valid), .current_unit(current_unit),
		.soft_reset_pulse(soft_reset_pulse), .unit_power(unit_power),
		.unit_auto_power(unit_auto_power), .pll_off(pll_off),
		.oscillator_stop(osc_stop), .baud_clock_generator_enable(baud_on),
		.qualify_16bit_address(qualify), .config_port_base(port_base));
	config_host_model host (.sys_clk(sys_clk), .io_rdata(io_rdata),
		.io_rdata_valid(io_rdata_valid), .io_req(io_req));

	initial forever #20 sys_clk = ~sys_clk;
	// ==========================================================
	// checking helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			mismatches++;
			$display("BAD %0t saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic expect_reg(input logic [7:0] idx, input logic [7:0] want);
		host.cfg_read(base, idx, rd, got);
		check(16'(got), 16'h0001);
		check(16'(rd), 16'(want));
	endtask
	task automatic pulse_reset(input int which);
		@(negedge sys_clk);
		{standby_por, main_por, reset} = 3'(1 << which);
		@(negedge sys_clk);
		{standby_por, main_por, reset} = 3'b000;
	endtask
	function automatic logic [15:0] osc_pins();
		return 16'({pll_off, osc_stop, baud_on, qualify});
	endfunction
	task automatic complete_run();
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_defaults();
		check(osc_pins(), 16'h0003);
		check(port_base, 16'h002E);
		expect_reg(IDX_OSCILLATOR_CONTROL, 8'h44);
		expect_reg(IDX_CONFIG_PORT_ADDRESS_LOW, 8'h2E);
		expect_reg(IDX_CONFIG_PORT_ADDRESS_HIGH, 8'h00);
		expect_reg(IDX_DEVICE_IDENTITY, ID_CODE);
		expect_reg(IDX_DEVICE_REVISION, REV_CODE);
		expect_reg(IDX_UNIT_POWER_CONTROL, 8'h00);
		expect_reg(IDX_UNIT_SELECT, 8'h00);
	endtask
	task automatic t_holes();
		logic [7:0] holes [12] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08,
			8'h1F, 8'h25, 8'h28, 8'h2F, 8'h30, 8'h87, 8'hA0};
		foreach (holes[i])
		begin
			host.cfg_write(base, holes[i], 8'hFF);
			expect_reg(holes[i], 8'h00);
		end
		check(16'(current_unit), 16'h0000);
		host.cfg_write(base, IDX_DEVICE_IDENTITY, 8'h00);
		expect_reg(IDX_DEVICE_IDENTITY, ID_CODE);
	endtask
	task automatic t_masks();
		host.cfg_write(base, IDX_UNIT_POWER_CONTROL, 8'hFF);
		expect_reg(IDX_UNIT_POWER_CONTROL, 8'h7D);
		check(16'(unit_power), 16'h007D);
		host.cfg_write(base, IDX_AUTO_POWER_MANAGEMENT, 8'hFF);
		expect_reg(IDX_AUTO_POWER_MANAGEMENT, 8'h79);
		check(16'(unit_auto_power), 16'h0079);
		host.cfg_write(base, IDX_OSCILLATOR_CONTROL, 8'hFF);
		expect_reg(IDX_OSCILLATOR_CONTROL, 8'h4E);
		check(osc_pins(), 16'h000D);
		for (int c = 0; c < 3; c++)
		begin
			host.cfg_write(base, IDX_OSCILLATOR_CONTROL, 8'(c << 2));
			check(osc_pins(), 16'h0002);
		end
		host.cfg_write(base, IDX_OSCILLATOR_CONTROL, 8'h44);
	endtask
	task automatic t_soft();
		host.cfg_write(base, IDX_UNIT_SELECT, 8'h05);
		host.io_cycle(1'b0, base | 16'h0001, 8'h00, rd, got);
		host.io_cycle(1'b0, base | 16'h0001, 8'h00, rd, got);
		check(16'({got, rd}), 16'h0105);
		host.io_cycle(1'b0, base, 8'h00, rd, got);
		check(16'({got, rd}), 16'h0107);
		check(16'(current_unit), 16'h0005);
		host.cfg_write(base, IDX_CONFIG_CONTROL, 8'h01);
		check(16'({soft_reset_pulse, current_unit}), 16'h0100);
		check(16'(unit_power), 16'h0020);
		expect_reg(IDX_CONFIG_CONTROL, 8'h00);
		expect_reg(IDX_AUTO_POWER_MANAGEMENT, 8'h79);
		expect_reg(IDX_OSCILLATOR_CONTROL, 8'h44);
	endtask
	task automatic t_mode();
		@(negedge sys_clk);
		config_mode = 1'b0;
		host.cfg_write(base, IDX_UNIT_SELECT, 8'h09);
		host.cfg_read(base, IDX_UNIT_SELECT, rd, got);
		check(16'(got), 16'h0000);
		config_mode = 1'b1;
		check(16'(current_unit), 16'h0000);
	endtask
	task automatic t_move();
		host.cfg_write(base, IDX_CONFIG_PORT_ADDRESS_LOW, 8'h4F);
		expect_reg(IDX_CONFIG_PORT_ADDRESS_LOW, 8'h4E);
		check(port_base, 16'h002E);
		host.cfg_write(base, IDX_CONFIG_PORT_ADDRESS_HIGH, 8'h12);
		check(port_base, 16'h124E);
		host.cfg_read(base, IDX_UNIT_SELECT, rd, got);
		check(16'(got), 16'h0000);
		base = 16'h124E;
		expect_reg(IDX_CONFIG_PORT_ADDRESS_HIGH, 8'h12);
		host.cfg_write(base, IDX_OSCILLATOR_CONTROL, 8'h04);
		host.cfg_read(16'h524E, IDX_CONFIG_PORT_ADDRESS_HIGH, rd, got);
		check(16'({got, rd}), 16'h0112);
		host.cfg_write(base, IDX_OSCILLATOR_CONTROL, 8'h44);
		strap = 1'b1;
		pulse_reset(0);
		base = 16'h004E;
		check(port_base, 16'h004E);
		check(16'(unit_power), 16'h0020);
		expect_reg(IDX_CONFIG_PORT_ADDRESS_HIGH, 8'h00);
		pulse_reset(2);
		check(16'(unit_power), 16'h0000);
		check(port_base, 16'h004E);
		strap = 1'b0;
		pulse_reset(1);
		check(port_base, 16'h002E);
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (20) @(negedge sys_clk);
		{standby_por, main_por, reset} = 3'b000;
		t_defaults();
		t_holes();
		t_masks();
		t_soft();
		t_mode();
		t_move();
		complete_run();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end
endmodule

`default_nettype wire
